// ==== rtl/ufp_trap.sv ====
// unimplemented floating-point trap sequencer with reset-instruction drive
`timescale 1ns/10ps
`default_nettype none

module ufp_trap (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // instruction from decode
    input  wire logic        op_valid,
    input  wire logic [15:0] op_word,
    input  wire logic [31:0] op_pc,
    input  wire logic [31:0] next_pc,
    input  wire logic [31:0] areg_value,
    input  wire logic [31:0] disp_value,
    input  wire logic [31:0] ext_address,
    // pipeline drain status
    input  wire logic        wb_busy,
    input  wire logic        wb_access_error,
    input  wire logic        exc_busy,
    input  wire logic        ae_return,
    // status word and stack
    input  wire logic [15:0] status_in,
    input  wire logic [31:0] super_sp,
    // frame push bus
    output logic             push_valid,
    input  wire logic        push_ready,
    output logic [31:0]      push_addr,
    output logic [15:0]      push_data,
    output logic [2:0]       push_fc,
    // exception reports
    output logic             ae_take,
    output logic             fp_pending,
    output logic             fline_other,
    output logic             trap_done,
    output logic [15:0]      status_word,
    output logic             busy,
    // reset pins
    input  wire logic        reset_instr,
    input  wire logic        external_reset_input_n,
    input  wire logic        cache_disable_pin,
    output logic             system_reset_output_n,
    output logic             core_reset
);
    ufp_pkg::ufp_state_t state_reg;
    logic [15:0]         sw_copy_reg;
    logic [31:0]         ea_reg;
    logic [31:0]         fppc_reg;
    logic [31:0]         rpc_reg;
    logic [15:0]         op_reg;
    logic [2:0]          idx_reg;
    logic [31:0]         sp_base_reg;
    logic [15:0]         push_data_reg;
    logic [31:0]         push_addr_reg;
    logic                ae_take_reg;
    logic                pend_reg;
    logic                other_reg;
    logic                done_reg;
    logic [15:0]         sw_reg;
    localparam int RST_CNT_W_L = ufp_pkg::RST_CNT_W;
    logic [RST_CNT_W_L-1:0] rst_cnt_reg;
    logic                rst_active_reg;
    logic                core_rst_reg;
    logic                ext_rst;
    logic                is_fline;
    logic                is_fp;
    logic [2:0]          mode;
    logic                ea_needed;
    logic [31:0]         ea_calc;
    logic [15:0]         sw_super;

    // the cache disable level is deliberately never looked at
    // only the non-latched, non-multiplexed bus timing exists here
    assign ext_rst  = !external_reset_input_n;
    assign is_fline = (op_word[ufp_pkg::OPC_HI -: 4] == ufp_pkg::FLINE_NIB);
    assign is_fp    = is_fline &&
                      (op_word[ufp_pkg::CPID_HI:ufp_pkg::CPID_LO] == ufp_pkg::FP_COPROC_ID);
    assign mode     = op_reg[ufp_pkg::MODE_HI:ufp_pkg::MODE_LO];
    // register and immediate operands have no address
    assign ea_needed = !(mode == ufp_pkg::MODE_DREG || mode == ufp_pkg::MODE_AREG ||
                         (mode == ufp_pkg::MODE_EXT &&
                          op_reg[ufp_pkg::REG_HI:0] == ufp_pkg::REG_IMMEDIATE));
    assign sw_super = {1'b0, 1'b0, 1'b1, status_in[12:0]};

    always_comb begin
        case (mode)
            ufp_pkg::MODE_PREDEC: ea_calc = areg_value - ufp_pkg::PREDEC_STEP;
            ufp_pkg::MODE_DISP:   ea_calc = areg_value + disp_value;
            ufp_pkg::MODE_EXT:    ea_calc = ext_address;
            default:              ea_calc = areg_value;
        endcase
    end

    // frame word n, lowest address first
    function automatic logic [15:0] frame_word(input logic [2:0] n, input logic [15:0] sw,
                                               input logic [31:0] rpc, input logic [31:0] ea,
                                               input logic [31:0] fpc);
        case (n)
            3'h0:    frame_word = sw;
            3'h1:    frame_word = rpc[31:16];
            3'h2:    frame_word = rpc[15:0];
            3'h3:    frame_word = {ufp_pkg::FRAME_FORMAT, ufp_pkg::FLINE_VEC_OFS};
            3'h4:    frame_word = ea[31:16];
            3'h5:    frame_word = ea[15:0];
            3'h6:    frame_word = fpc[31:16];
            default: frame_word = fpc[15:0];
        endcase
    endfunction : frame_word

    // trap sequencer; an external reset restarts it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg     <= ufp_pkg::ST_IDLE;
            sw_copy_reg   <= 16'h0000;
            ea_reg        <= 32'h0000_0000;
            fppc_reg      <= 32'h0000_0000;
            rpc_reg       <= 32'h0000_0000;
            op_reg        <= 16'h0000;
            idx_reg       <= 3'h0;
            sp_base_reg   <= 32'h0000_0000;
            push_data_reg <= 16'h0000;
            push_addr_reg <= 32'h0000_0000;
            ae_take_reg   <= 1'b0;
            pend_reg      <= 1'b0;
            other_reg     <= 1'b0;
            done_reg      <= 1'b0;
        end else if (ext_rst) begin
            state_reg   <= ufp_pkg::ST_IDLE;
            ae_take_reg <= 1'b0;
            pend_reg    <= 1'b0;
            other_reg   <= 1'b0;
            done_reg    <= 1'b0;
        end else begin
            ae_take_reg <= 1'b0;
            other_reg   <= 1'b0;
            done_reg    <= 1'b0;
            case (state_reg)
                ufp_pkg::ST_IDLE: begin
                    if (op_valid && is_fp) begin
                        op_reg    <= op_word;
                        fppc_reg  <= op_pc;
                        rpc_reg   <= next_pc;
                        state_reg <= ufp_pkg::ST_DECODE;
                    end else if (op_valid && is_fline) begin
                        other_reg <= 1'b1;
                    end
                end
                ufp_pkg::ST_DECODE: begin
                    ea_reg    <= ea_needed ? ea_calc : 32'h0000_0000;
                    state_reg <= ufp_pkg::ST_DRAIN;
                end
                ufp_pkg::ST_DRAIN: begin
                    if (wb_access_error) begin
                        ae_take_reg <= 1'b1;
                        pend_reg    <= 1'b1;
                        state_reg   <= ufp_pkg::ST_AEWAIT;
                    end else if (!wb_busy && !exc_busy) begin
                        state_reg <= ufp_pkg::ST_SWCOPY;
                    end
                end
                ufp_pkg::ST_AEWAIT: begin
                    // handler finished the write-backs in software
                    if (ae_return) begin
                        pend_reg  <= 1'b0;
                        state_reg <= ufp_pkg::ST_SWCOPY;
                    end
                end
                ufp_pkg::ST_SWCOPY: begin
                    sw_copy_reg   <= status_in;
                    sp_base_reg   <= super_sp - ufp_pkg::FRAME_BYTES;
                    push_addr_reg <= super_sp - ufp_pkg::FRAME_BYTES;
                    push_data_reg <= status_in;
                    idx_reg       <= 3'h0;
                    state_reg     <= ufp_pkg::ST_PUSH;
                end
                ufp_pkg::ST_PUSH: begin
                    if (push_ready) begin
                        if (idx_reg == 3'(ufp_pkg::FRAME_WORDS - 1)) begin
                            state_reg <= ufp_pkg::ST_DONE;
                        end else begin
                            idx_reg       <= idx_reg + 3'h1;
                            push_addr_reg <= push_addr_reg + ufp_pkg::WORD_BYTES;
                            push_data_reg <= frame_word(idx_reg + 3'h1, sw_copy_reg,
                                                        rpc_reg, ea_reg, fppc_reg);
                        end
                    end
                end
                ufp_pkg::ST_DONE: begin
                    done_reg  <= 1'b1;
                    state_reg <= ufp_pkg::ST_IDLE;
                end
                default: state_reg <= ufp_pkg::ST_IDLE;
            endcase
        end
    end

    // supervisor status is loaded at the end of the copy cycle, in effect from the first push cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sw_reg <= 16'h0000;
        end else if (state_reg == ufp_pkg::ST_SWCOPY) begin
            sw_reg <= sw_super;
        end else if (state_reg == ufp_pkg::ST_IDLE) begin
            sw_reg <= status_in;
        end
    end

    // reset instruction: counts clocks, touches nothing else
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt_reg    <= '0;
            rst_active_reg <= 1'b0;
            core_rst_reg   <= 1'b0;
        end else begin
            core_rst_reg <= 1'b0;
            if (ext_rst) begin
                rst_active_reg <= 1'b0;
                rst_cnt_reg    <= '0;
                core_rst_reg   <= rst_active_reg;
            end else if (rst_active_reg) begin
                if (rst_cnt_reg == RST_CNT_W_L'(ufp_pkg::RESET_OUT_CYCLES - 1)) begin
                    rst_active_reg <= 1'b0;
                end
                rst_cnt_reg <= rst_cnt_reg + 1'b1;
            end else if (reset_instr) begin
                rst_active_reg <= 1'b1;
                rst_cnt_reg    <= '0;
            end
        end
    end

    assign push_valid            = (state_reg == ufp_pkg::ST_PUSH);
    assign push_addr             = push_addr_reg;
    assign push_data             = push_data_reg;
    assign push_fc               = ufp_pkg::FC_SUPER_DATA;
    assign ae_take               = ae_take_reg;
    assign fp_pending            = pend_reg;
    assign fline_other           = other_reg;
    assign trap_done             = done_reg;
    assign status_word           = sw_reg;
    assign busy                  = (state_reg != ufp_pkg::ST_IDLE);
    assign system_reset_output_n = !rst_active_reg;
    assign core_reset            = core_rst_reg;

    chk_push_super: assert property (@(posedge clk_sys) disable iff (!arst_n)
        push_valid |-> (sw_reg[ufp_pkg::SW_SUPER] && !sw_reg[ufp_pkg::SW_TRACE_HIGH] &&
                        !sw_reg[ufp_pkg::SW_TRACE_LOW]))
        else $error("frame pushed outside supervisor state");
    chk_frame_space: assert property (@(posedge clk_sys) disable iff (!arst_n)
        push_valid |-> push_fc == ufp_pkg::FC_SUPER_DATA &&
                       push_addr - sp_base_reg == {28'h0, idx_reg, 1'b0})
        else $error("frame word at wrong place");
    chk_frame_format: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (push_valid && idx_reg == 3'h3) |->
            push_data == {ufp_pkg::FRAME_FORMAT, ufp_pkg::FLINE_VEC_OFS})
        else $error("format word wrong");
    chk_frame_sw: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (push_valid && idx_reg == 3'h0) |-> push_data == sw_copy_reg)
        else $error("saved status word wrong");
    chk_other_fline: assert property (@(posedge clk_sys) disable iff (!arst_n || ext_rst)
        (state_reg == ufp_pkg::ST_IDLE && op_valid && is_fline && !is_fp) |=>
            fline_other && !busy)
        else $error("other F-line opcode mishandled");
    chk_drain_wait: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_reg == ufp_pkg::ST_DRAIN && (wb_busy || exc_busy)) |=>
            state_reg != ufp_pkg::ST_SWCOPY)
        else $error("trap started before drain");
    chk_ae_pending: assert property (@(posedge clk_sys) disable iff (!arst_n || ext_rst)
        (state_reg == ufp_pkg::ST_DRAIN && wb_access_error) |=> ae_take && fp_pending ##1 !ae_take)
        else $error("access error not flagged pending");
    chk_ae_resume: assert property (@(posedge clk_sys) disable iff (!arst_n || ext_rst)
        (state_reg == ufp_pkg::ST_AEWAIT && ae_return) |=>
            state_reg == ufp_pkg::ST_SWCOPY ##1 push_valid)
        else $error("trap not resumed after access error return");
    chk_reg_no_ea: assert property (@(posedge clk_sys) disable iff (!arst_n || ext_rst)
        (state_reg == ufp_pkg::ST_DECODE && !ea_needed) |=> ea_reg == 32'h0000_0000)
        else $error("address formed for register operand");
    chk_reset_len: assert property (@(posedge clk_sys) disable iff (!arst_n || ext_rst)
        $fell(system_reset_output_n) |-> !system_reset_output_n [*8] ##0
            (rst_cnt_reg == RST_CNT_W_L'(7)))
        else $error("reset output length wrong");
    chk_ext_reset: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ext_rst && !system_reset_output_n) |=> system_reset_output_n && core_reset)
        else $error("external reset did not release output");
endmodule : ufp_trap

`default_nettype wire

// ==== rtl/ufp_pkg.sv ====
// shared constants for the unimplemented floating-point trap sequencer
package ufp_pkg;
    localparam logic [3:0]  FLINE_NIB      = 4'hF;   // opword[15:12] of an F-line opcode
    localparam logic [2:0]  FP_COPROC_ID   = 3'h1;   // opword[11:9] of a floating-point opcode
    localparam int          OPC_HI         = 15;
    localparam int          CPID_HI        = 11;
    localparam int          CPID_LO        = 9;
    localparam int          MODE_HI        = 5;
    localparam int          MODE_LO        = 3;
    localparam int          REG_HI         = 2;
    // addressing modes in opword[5:3]
    localparam logic [2:0]  MODE_DREG      = 3'h0;
    localparam logic [2:0]  MODE_AREG      = 3'h1;
    localparam logic [2:0]  MODE_IND       = 3'h2;
    localparam logic [2:0]  MODE_POSTINC   = 3'h3;
    localparam logic [2:0]  MODE_PREDEC    = 3'h4;
    localparam logic [2:0]  MODE_DISP      = 3'h5;
    localparam logic [2:0]  MODE_EXT       = 3'h7;
    localparam logic [2:0]  REG_IMMEDIATE  = 3'h4;   // mode 7 reg 4 is immediate data
    localparam logic [31:0] PREDEC_STEP    = 32'h0000_0004;
    // format 4 frame
    localparam logic [3:0]  FRAME_FORMAT   = 4'h4;
    localparam logic [11:0] FLINE_VEC_OFS  = 12'h02C;
    localparam int          FRAME_WORDS    = 8;
    localparam logic [31:0] FRAME_BYTES    = 32'h0000_0010;
    localparam logic [31:0] WORD_BYTES     = 32'h0000_0002;
    localparam logic [2:0]  FC_SUPER_DATA  = 3'h5;
    // status word bits
    localparam int          SW_TRACE_HIGH  = 15;
    localparam int          SW_TRACE_LOW   = 14;
    localparam int          SW_SUPER       = 13;
    // reset instruction drive length in bus clocks
    localparam int          RESET_OUT_CYCLES = 512;
    localparam int          RST_CNT_W        = 10;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'b000_0001,
        ST_DECODE = 7'b000_0010,
        ST_DRAIN  = 7'b000_0100,
        ST_AEWAIT = 7'b000_1000,
        ST_SWCOPY = 7'b001_0000,
        ST_PUSH   = 7'b010_0000,
        ST_DONE   = 7'b100_0000
    } ufp_state_t;
endpackage : ufp_pkg

// ==== tb/ufp_far_side.sv ====
// frame sink on the push bus and external reset source
`timescale 1ns/10ps
`default_nettype none
module ufp_far_side (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // frame push bus
    input  wire logic        push_valid,
    output logic             push_ready,
    input  wire logic [31:0] push_addr,
    input  wire logic [15:0] push_data,
    input  wire logic [2:0]  push_fc,
    // bench control
    input  wire logic        slow,
    input  wire logic        rst_req,
    output logic             external_reset_input_n
);
    logic [31:0] word_addr [8];
    logic [15:0] word_data [8];
    logic [2:0]  word_fc   [8];
    int          count;

    assign external_reset_input_n = !rst_req;

    // slow mode stalls every other cycle so held words are exercised
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            push_ready <= 1'b0;
            count      <= 0;
        end else begin
            push_ready <= slow ? !push_ready : 1'b1;
            if (push_valid && push_ready) begin
                word_addr[count % 8] <= push_addr;
                word_data[count % 8] <= push_data;
                word_fc[count % 8]   <= push_fc;
                count                <= count + 1;
            end
        end
    end
endmodule : ufp_far_side
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the floating-point trap sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk_sys = 1'b0;
    logic        arst_n, op_valid, wb_busy, wb_access_error, exc_busy, ae_return;
    logic        reset_instr, cache_disable_pin, slow, rst_req, external_reset_input_n;
    logic [15:0] op_word, status_in;
    logic [31:0] op_pc, next_pc, areg_value, disp_value, ext_address, super_sp;
    logic        push_valid, push_ready, ae_take, fp_pending, fline_other, trap_done, busy;
    logic        system_reset_output_n, core_reset;
    logic [31:0] push_addr;
    logic [15:0] push_data, status_word;
    logic [2:0]  push_fc;
    int          bad_count = 0;
    int          tests_run = 0;

    ufp_trap dut_u (.clk_sys, .arst_n, .op_valid, .op_word, .op_pc, .next_pc, .areg_value,
        .disp_value, .ext_address, .wb_busy, .wb_access_error, .exc_busy, .ae_return,
        .status_in, .super_sp, .push_valid, .push_ready, .push_addr, .push_data, .push_fc,
        .ae_take, .fp_pending, .fline_other, .trap_done, .status_word, .busy, .reset_instr,
        .external_reset_input_n, .cache_disable_pin, .system_reset_output_n, .core_reset);
    ufp_far_side far_u (.clk_sys, .arst_n, .push_valid, .push_ready, .push_addr, .push_data,
        .push_fc, .slow, .rst_req, .external_reset_input_n);

    always #50 clk_sys = ~clk_sys;

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    // 0 trap_done, 1 ae_take, 2 fline_other, 3 push_valid
    task automatic wait_on(input int which, input int limit);
        bit hit;
        int n;
        hit = 1'b0;
        n = 0;
        while (!hit) begin
            @(posedge clk_sys);
            #1;
            case (which)
                0: hit = (trap_done === 1'b1);
                1: hit = (ae_take === 1'b1);
                2: hit = (fline_other === 1'b1);
                default: hit = (push_valid === 1'b1);
            endcase
            n++;
            if (!hit && n >= limit) begin
                $display("ERROR wait %0d ran out", which);
                bad_count++;
                results();
            end
        end
    endtask : wait_on

    task automatic issue(input logic [15:0] w);
        @(posedge clk_sys);
        op_valid <= 1'b1;
        op_word  <= w;
        @(posedge clk_sys);
        op_valid <= 1'b0;
    endtask : issue

    function automatic logic [31:0] exp_ea(input logic [2:0] m, input logic [2:0] r);
        case (m)
            3'h0, 3'h1: return 32'h0;
            3'h4: return areg_value - ufp_pkg::PREDEC_STEP;
            3'h5: return areg_value + disp_value;
            3'h7: return (r == ufp_pkg::REG_IMMEDIATE) ? 32'h0 : ext_address;
            default: return areg_value;
        endcase
    endfunction : exp_ea

    // frame pushed after the status switch, then compared word by word
    task automatic finish_trap(input int base, input logic [31:0] ea);
        logic [15:0] w [8];
        logic [31:0] a0;
        a0 = super_sp - ufp_pkg::FRAME_BYTES;
        w = '{status_in, next_pc[31:16], next_pc[15:0],
              {ufp_pkg::FRAME_FORMAT, ufp_pkg::FLINE_VEC_OFS},
              ea[31:16], ea[15:0], op_pc[31:16], op_pc[15:0]};
        wait_on(3, 40);
        check("status at push", {16'h0, status_word},
              {16'h0, status_in & 16'h3FFF | 16'h2000});
        wait_on(0, 60);
        check("frame words", 32'(far_u.count - base), 32'(ufp_pkg::FRAME_WORDS));
        for (int i = 0; i < 8; i++) begin
            check("frame data", {16'h0, far_u.word_data[(base + i) % 8]},
                  {16'h0, w[i]});
            check("frame addr", far_u.word_addr[(base + i) % 8], a0 + 32'(2 * i));
            check("frame fc", {29'h0, far_u.word_fc[(base + i) % 8]},
                  {29'h0, ufp_pkg::FC_SUPER_DATA});
        end
    endtask : finish_trap

    // every addressing mode, with the ignored cache pin high
    task automatic t_modes;
        logic [2:0] m [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7};
        logic [2:0] r [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4};
        int base;
        cache_disable_pin <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            base = far_u.count;
            issue({4'hF, 3'h1, 3'h0, m[i], r[i]});
            finish_trap(base, exp_ea(m[i], r[i]));
        end
    endtask : t_modes

    task automatic t_drain;
        int base;
        base = far_u.count;
        slow <= 1'b1;
        wb_busy <= 1'b1;
        exc_busy <= 1'b1;
        issue(16'hF228);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            if (i == 3) wb_busy <= 1'b0;
            #1;
            check("push while draining", {31'h0, push_valid}, 32'h0);
        end
        @(posedge clk_sys);
        exc_busy <= 1'b0;
        finish_trap(base, areg_value + disp_value);
        slow <= 1'b0;
    endtask : t_drain

    task automatic t_access_error;
        int base;
        base = far_u.count;
        wb_access_error <= 1'b1;
        issue(16'hF210);
        wait_on(1, 20);
        check("pending flag", {31'h0, fp_pending}, 32'h1);
        @(posedge clk_sys);
        wb_access_error <= 1'b0;
        repeat (4) begin
            @(posedge clk_sys);
            #1;
            check("push before return", {31'h0, push_valid}, 32'h0);
        end
        @(posedge clk_sys);
        ae_return <= 1'b1;
        @(posedge clk_sys);
        ae_return <= 1'b0;
        finish_trap(base, areg_value);
        check("pending cleared", {31'h0, fp_pending}, 32'h0);
    endtask : t_access_error

    task automatic t_other_fline;
        int base;
        base = far_u.count;
        issue(16'hF400);
        // the pulse stands only in the cycle right after the opcode is taken
        #1;
        check("other F-line pulse", {31'h0, fline_other}, 32'h1);
        repeat (10) @(posedge clk_sys);
        #1;
        check("no frame pushed", 32'(far_u.count - base), 32'h0);
        check("idle after", {31'h0, busy}, 32'h0);
    endtask : t_other_fline

    task automatic t_reset_instr;
        int n;
        logic [15:0] sw;
        sw = status_word;
        n = 0;
        @(posedge clk_sys);
        reset_instr <= 1'b1;
        @(posedge clk_sys);
        reset_instr <= 1'b0;
        #1;
        repeat (600) begin
            if (system_reset_output_n === 1'b0) n++;
            @(posedge clk_sys);
            #1;
        end
        check("reset drive length", 32'(n), 32'(ufp_pkg::RESET_OUT_CYCLES));
        check("status kept", {16'h0, status_word}, {16'h0, sw});
    endtask : t_reset_instr

    task automatic t_ext_reset;
        bit rel, hit;
        rel = 1'b0;
        hit = 1'b0;
        @(posedge clk_sys);
        reset_instr <= 1'b1;
        @(posedge clk_sys);
        reset_instr <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_req <= 1'b1;
        repeat (2) begin
            @(posedge clk_sys);
            #1;
            rel |= (system_reset_output_n === 1'b1);
            hit |= (core_reset === 1'b1);
        end
        rst_req <= 1'b0;
        check("reset out released", {31'h0, rel}, 32'h1);
        check("core reset pulse", {31'h0, hit}, 32'h1);
    endtask : t_ext_reset

    initial begin
        {arst_n, op_valid, wb_busy, wb_access_error, exc_busy, ae_return} = '0;
        {reset_instr, cache_disable_pin, slow, rst_req} = '0;
        op_word = 16'h0;
        status_in = 16'hC015;
        op_pc = 32'h0000_2468;
        next_pc = 32'h0000_246C;
        areg_value = 32'h0001_0800;
        disp_value = 32'h0000_0024;
        ext_address = 32'h0003_4560;
        super_sp = 32'h0000_8000;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_modes();
        t_drain();
        t_access_error();
        t_other_fline();
        t_reset_instr();
        t_ext_reset();
        results();
    end
endmodule : testbench
`default_nettype wire
